// ===== rtl/adc_ctrl_consts.svh
// Constants for the converter reference, timing and pin control block
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
// ==========================================
// Register indexes (byte address = 4 * index)
`define IDX_PIN_CFG 8'hae
`define IDX_REF_SEL 8'haf
`define IDX_MODE 8'hb1
`define IDX_RES_HI 8'hb2
`define IDX_CLK_RES 8'hb3
`define IDX_IRQ_CTL 8'hb4
// ==========================================
// Field positions
`define MODE_PWR 7
`define MODE_START 6
`define MODE_EOC 5
`define MODE_GCH 4
`define REF_EXT 7
`define CLK_DIV1 6
`define CLK_RES 5
`define CLK_DIV0 4
`define IRQ_FLAG 0
`define IRQ_EN 1
// ==========================================
// Reset values
`define RST_BYTE 8'h00
`define RST_DIV 2'h0
`define RST_CH 3'h0
`define RST_PINS 5'h00
// ==========================================
// Converter clock divider selections and ratios
`define DIV_16 2'h0
`define DIV_8 2'h1
`define DIV_1 2'h2
`define DIV_2 2'h3
`define RATIO_16 5'h10
`define RATIO_8 5'h08
`define RATIO_1 5'h01
`define RATIO_2 5'h02
// ==========================================
// Conversion length: quarter periods times converter clocks per quarter
`define QUARTERS_12 7'h10
`define QUARTERS_8 7'h0c
`define CLKS_PER_QUARTER 7'h04
// ==========================================
// Saturated results
`define RESULT_FULL 12'hfff
`define RESULT_ZERO 12'h000
`endif

// ===== rtl/adc_ctrl_pkg.sv
// Types shared by the converter control block
package adc_ctrl_pkg;
  typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_t;
endpackage

// ===== rtl/conv_timer_if.sv
// Carrier between the control core and the conversion timer
`timescale 1ns/1ps
interface conv_timer_if;
  logic start;
  logic abort;
  logic [1:0] div_sel;
  logic res12;
  logic done;
  modport ctrl (output start, output abort, output div_sel, output res12, input done);
  modport timer (input start, input abort, input div_sel, input res12, output done);
endinterface

// ===== rtl/conv_timer.sv
// Converter clock divider and conversion length counter
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"
module conv_timer
  import adc_ctrl_pkg::*;
#(
  parameter int CNT_W = 7
)(
  input wire logic clock_i,
  input wire logic rst_i,
  conv_timer_if.timer tif
);
  logic [4:0] ratio;
  logic [4:0] div_r;
  logic tick;
  logic [CNT_W-1:0] left_r;
  logic [CNT_W-1:0] len;
  logic busy_r;

  // ==========================================
  // Converter clock enable
  always_comb
  begin
    case (tif.div_sel)
      `DIV_16: ratio = `RATIO_16;
      `DIV_8: ratio = `RATIO_8;
      `DIV_1: ratio = `RATIO_1;
      `DIV_2: ratio = `RATIO_2;
      default: ratio = `RATIO_16;
    endcase
  end

  assign tick = busy_r && (div_r == ratio - 5'h01);

  // Restart on start so every conversion has the exact length
  always_ff @(posedge clock_i)
  begin
    if (rst_i || tif.start || tick)
      div_r <= 5'h00;
    else if (busy_r)
      div_r <= div_r + 5'h01;
  end

  // ==========================================
  // Conversion length counter
  assign len = tif.res12 ? CNT_W'(`QUARTERS_12 * `CLKS_PER_QUARTER)
                         : CNT_W'(`QUARTERS_8 * `CLKS_PER_QUARTER);

  always_ff @(posedge clock_i)
  begin
    if (rst_i || tif.abort)
      busy_r <= 1'b0;
    else if (tif.start)
      busy_r <= 1'b1;
    else if (tick && left_r == CNT_W'(1))
      busy_r <= 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      left_r <= '0;
    else if (tif.start)
      left_r <= len;
    else if (tick)
      left_r <= left_r - CNT_W'(1);
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      tif.done <= 1'b0;
    else
      tif.done <= busy_r && !tif.abort && !tif.start && tick && left_r == CNT_W'(1);
  end

  // ==========================================
  // Checks
  logic [11:0] elapsed_r;
  logic [11:0] expect_r;
  always_ff @(posedge clock_i)
  begin
    if (rst_i || tif.start)
      elapsed_r <= 12'h000;
    else
      elapsed_r <= elapsed_r + 12'h001;
  end
  always_ff @(posedge clock_i)
  begin
    if (tif.start)
      expect_r <= 12'(len) * 12'(ratio);
  end

  a_conv_length: assert property (@(posedge clock_i) disable iff (rst_i)
    tif.done |-> elapsed_r == expect_r)
    else $error("conversion length wrong");
endmodule

// ===== rtl/adc_ctrl.sv
// Converter reference, timing, channel and pin control with Avalon-MM registers
// Operation
// - External select set: high reference comes from the port bit zero pin.
// - External select clear: high reference is the internal level chosen.
// - Internal level: 11 supply, 10 4.0V, 01 3.0V, 00 2.0V.
// - External select disables internal reference and claims the shared pin.
// - Conversion time runs from start bit set to end flag set.
// - Twelve-bit conversion lasts 64 converter clock cycles.
// - Eight-bit conversion lasts 48 converter clock cycles.
// - Divider select: 00 by 16, 01 by 8, 10 by 1, 11 by 2.
// - Resolution bit: 1 twelve-bit, 0 eight-bit, sets conversion length.
// - Channel select value addresses the analog input directly.
// - Only the single selected channel reaches the converter.
// - Each analog config bit set makes its pin purely analog.
// - Out of range input saturates to all ones or all zeros.
// - At end of conversion start bit clears and end flag sets.
// - End flag shows status and clears whenever start bit is set; the code keeps it set when done falls in the same cycle as the start.
// - End of conversion raises the interrupt request flag.
// - Result bits 11..4 to high byte, 3..0 to low nibble.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"
module adc_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int CHANNELS = 6,
  parameter int PINS = 5
)(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [9:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic [11:0] conv_data_i,
  input wire logic over_range_i,
  input wire logic under_range_i,
  output logic conv_power_o,
  output logic converting_o,
  output logic ext_ref_pin_en_o,
  output logic [3:0] int_ref_tap_o,
  output logic [CHANNELS-1:0] channel_sel_o,
  output logic [PINS-1:0] pin_analog_only_o,
  output logic conv_irq_o
);
  conv_timer_if tif ();
  conv_state_t state_r;

  logic [7:0] idx;
  logic take;
  logic wr;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  logic power_r;
  logic start_r;
  logic eoc_r;
  logic gch_r;
  logic [2:0] ch_r;
  logic ext_ref_r;
  logic [1:0] level_r;
  logic [1:0] div_r;
  logic res12_r;
  logic [PINS-1:0] pin_cfg_r;
  logic [11:0] result_r;
  logic irq_flag_r;
  logic irq_en_r;
  logic go_r;
  logic go_nxt;
  logic stop;

  // ==========================================
  // Avalon-MM slave: one wait state, then the answer
  assign idx = address_i[9:2];
  assign take = (read_i || write_i) && !waitrequest_o;
  assign wr = take && write_i && byteenable_i[0];
  assign wbyte = writedata_i[7:0];

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      waitrequest_o <= 1'b1;
    else
      waitrequest_o <= !((read_i || write_i) && waitrequest_o);
  end

  always_comb
  begin
    case (idx)
      `IDX_REF_SEL: rbyte = {ext_ref_r, 5'h00, level_r};
      `IDX_MODE: rbyte = {power_r, start_r, eoc_r, gch_r, 1'b0, ch_r};
      `IDX_RES_HI: rbyte = result_r[11:4];
      `IDX_CLK_RES: rbyte = {1'b0, div_r[1], res12_r, div_r[0], result_r[3:0]};
      `IDX_IRQ_CTL: rbyte = {6'h00, irq_en_r, irq_flag_r};
      default: rbyte = `RST_BYTE;
    endcase
  end

  // Pin configuration is write only and unmapped space reads zero
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      readdata_o <= 32'h0000_0000;
    else if (read_i && waitrequest_o)
      readdata_o <= {24'h000000, rbyte};
  end

  // ==========================================
  // Configuration registers
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ext_ref_r <= 1'b0;
      level_r <= 2'h0;
    end
    else if (wr && idx == `IDX_REF_SEL)
    begin
      ext_ref_r <= wbyte[`REF_EXT];
      level_r <= wbyte[1:0];
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      div_r <= `RST_DIV;
      res12_r <= 1'b0;
    end
    else if (wr && idx == `IDX_CLK_RES)
    begin
      div_r <= {wbyte[`CLK_DIV1], wbyte[`CLK_DIV0]};
      res12_r <= wbyte[`CLK_RES];
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      pin_cfg_r <= `RST_PINS;
    else if (wr && idx == `IDX_PIN_CFG)
      pin_cfg_r <= wbyte[PINS-1:0];
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      power_r <= 1'b0;
      gch_r <= 1'b0;
      ch_r <= `RST_CH;
    end
    else if (wr && idx == `IDX_MODE)
    begin
      power_r <= wbyte[`MODE_PWR];
      gch_r <= wbyte[`MODE_GCH];
      ch_r <= wbyte[2:0];
    end
  end

  // ==========================================
  // Start, end flag and state
  // A start written without the power bit set in the same write is dropped; clearing the start bit aborts
  assign go_nxt = wr && idx == `IDX_MODE && wbyte[`MODE_START] && wbyte[`MODE_PWR];
  assign stop = wr && idx == `IDX_MODE && !(wbyte[`MODE_START] && wbyte[`MODE_PWR]);

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      go_r <= 1'b0;
    else
      go_r <= go_nxt;
  end

  assign tif.start = go_r;
  assign tif.abort = stop && state_r == CONV_RUN;
  assign tif.div_sel = div_r;
  assign tif.res12 = res12_r;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      state_r <= CONV_IDLE;
    else
      case (state_r)
        CONV_IDLE: if (go_r) state_r <= CONV_RUN;
        CONV_RUN: if (tif.done || stop) state_r <= CONV_IDLE;
        default: state_r <= CONV_IDLE;
      endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      start_r <= 1'b0;
    else if (go_nxt)
      start_r <= 1'b1;
    else if (tif.done || stop)
      start_r <= 1'b0;
  end

  // Done wins over a software write of the same cycle
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      eoc_r <= 1'b0;
    else if (tif.done)
      eoc_r <= 1'b1;
    else if (go_nxt)
      eoc_r <= 1'b0;
    else if (wr && idx == `IDX_MODE)
      eoc_r <= wbyte[`MODE_EOC];
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      irq_flag_r <= 1'b0;
      irq_en_r <= 1'b0;
    end
    else
    begin
      if (tif.done)
        irq_flag_r <= 1'b1;
      else if (wr && idx == `IDX_IRQ_CTL)
        irq_flag_r <= wbyte[`IRQ_FLAG];
      if (wr && idx == `IDX_IRQ_CTL)
        irq_en_r <= wbyte[`IRQ_EN];
    end
  end

  // Result is undefined until the first conversion, so no reset
  always_ff @(posedge clock_i)
  begin
    if (tif.done)
    begin
      if (over_range_i)
        result_r <= `RESULT_FULL;
      else if (under_range_i)
        result_r <= `RESULT_ZERO;
      else
        result_r <= conv_data_i;
    end
  end

  // ==========================================
  // Analog side controls
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      conv_power_o <= 1'b0;
      converting_o <= 1'b0;
      ext_ref_pin_en_o <= 1'b0;
      int_ref_tap_o <= 4'h0;
      pin_analog_only_o <= '0;
      conv_irq_o <= 1'b0;
    end
    else
    begin
      conv_power_o <= power_r;
      converting_o <= state_r == CONV_RUN;
      ext_ref_pin_en_o <= ext_ref_r;
      int_ref_tap_o <= ext_ref_r ? 4'h0 : 4'h1 << level_r;
      pin_analog_only_o <= pin_cfg_r;
      conv_irq_o <= irq_flag_r && irq_en_r;
    end
  end

  // Channel 0 shares the reference pin, so it is never routed while that pin is claimed
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      channel_sel_o <= '0;
    else if (gch_r && power_r && int'(ch_r) < CHANNELS && !(ext_ref_r && ch_r == 3'h0))
      channel_sel_o <= CHANNELS'(1) << ch_r;
    else
      channel_sel_o <= '0;
  end

  conv_timer #(
    .CNT_W(7)
  ) u_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tif(tif.timer)
  );

  // ==========================================
  // Checks
  a_eoc_after_done: assert property (@(posedge clock_i) disable iff (rst_i)
    tif.done && !go_nxt |=> eoc_r && !start_r)
    else $error("end flag or start bit wrong after done");

  a_eoc_clr_start: assert property (@(posedge clock_i) disable iff (rst_i)
    go_nxt && !tif.done |=> !eoc_r && start_r)
    else $error("end flag not cleared by start");

  a_irq_on_done: assert property (@(posedge clock_i) disable iff (rst_i)
    tif.done |=> irq_flag_r ##1 (conv_irq_o == irq_en_r))
    else $error("interrupt flag not raised");

  a_ext_ref_pin: assert property (@(posedge clock_i) disable iff (rst_i)
    ext_ref_r |=> ext_ref_pin_en_o && int_ref_tap_o == 4'h0)
    else $error("external reference not selected");

  a_int_ref_tap: assert property (@(posedge clock_i) disable iff (rst_i)
    !ext_ref_r && level_r == 2'h3 |=> int_ref_tap_o == 4'h8 && !ext_ref_pin_en_o)
    else $error("supply tap not selected");

  a_one_channel: assert property (@(posedge clock_i) disable iff (rst_i)
    $onehot0(channel_sel_o))
    else $error("more than one channel routed");

  a_chan_decode: assert property (@(posedge clock_i) disable iff (rst_i)
    gch_r && power_r && !ext_ref_r && ch_r == 3'h1 |=> channel_sel_o == CHANNELS'(2))
    else $error("channel decode wrong");

  a_saturate_high: assert property (@(posedge clock_i) disable iff (rst_i)
    tif.done && over_range_i |=> result_r == `RESULT_FULL)
    else $error("result not saturated high");

  a_pin_analog: assert property (@(posedge clock_i) disable iff (rst_i)
    ##1 pin_analog_only_o == $past(pin_cfg_r))
    else $error("analog pin mask wrong");

  a_one_wait: assert property (@(posedge clock_i) disable iff (rst_i)
    (read_i || write_i) && waitrequest_o |=> !waitrequest_o ##1 waitrequest_o)
    else $error("bus answer timing wrong");
endmodule

// ===== verification/analog_source.sv
// Behavioural model of the analog inputs behind the channel route
`timescale 1ns/1ps
module analog_source (
  input wire logic clock_i,
  input wire logic [5:0] channel_sel_i,
  input wire logic [1:0] level_i,
  output logic [11:0] conv_data_o,
  output logic over_range_o,
  output logic under_range_o
);
  logic [11:0] noise_r = 12'h000;
  always_ff @(posedge clock_i)
  begin
    noise_r <= noise_r + 12'h3c7;
  end
  // Unrouted input shows a moving pattern, never a stale sample
  always_comb
  begin
    conv_data_o = noise_r;
    for (int i = 0; i < 6; i++)
      if (channel_sel_i == (6'h01 << i)) conv_data_o = 12'h5a0 | 12'(i);
    // Level 3 raises both, so the bench sees high saturation win
    over_range_o = level_i[0];
    under_range_o = level_i[1];
  end
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"
module testbench;
  import adc_ctrl_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] address_i = 10'h000;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic [3:0] byteenable_i = 4'h1;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  logic [11:0] conv_data_i;
  logic over_range_i;
  logic under_range_i;
  logic conv_power_o;
  logic converting_o;
  logic ext_ref_pin_en_o;
  logic conv_irq_o;
  logic [3:0] int_ref_tap_o;
  logic [5:0] channel_sel_o;
  logic [4:0] pin_analog_only_o;
  logic [1:0] level = 2'h0;
  int mismatches = 0;
  int comparisons = 0;
  int offset = -1;

  adc_ctrl adc_ctrl_inst (.clock_i(clock_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .conv_data_i(conv_data_i), .over_range_i(over_range_i),
    .under_range_i(under_range_i), .conv_power_o(conv_power_o), .converting_o(converting_o),
    .ext_ref_pin_en_o(ext_ref_pin_en_o), .int_ref_tap_o(int_ref_tap_o), .channel_sel_o(channel_sel_o),
    .pin_analog_only_o(pin_analog_only_o), .conv_irq_o(conv_irq_o));
  analog_source analog_source_inst (.clock_i(clock_i), .channel_sel_i(channel_sel_o), .level_i(level),
    .conv_data_o(conv_data_i), .over_range_o(over_range_i), .under_range_o(under_range_i));

  initial
  begin
    forever #10 clock_i = ~clock_i;
  end

  // ==========================================
  // Shared checking and bus tasks
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [7:0] data, output logic [31:0] q);
    int n;
    @(posedge clock_i);
    address_i <= {idx, 2'b00};
    writedata_i <= {24'h0, data};
    write_i <= wr_en;
    read_i <= !wr_en;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 50);
    q = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
    if (n >= 50) check(1'b0, 1'b1, "bus answer");
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    logic [31:0] q;
    bus(1'b1, idx, data, q);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(q, {24'h0, exp}, what);
  endtask

  // ==========================================
  // Scenarios
  task automatic test_reset;
    rd(`IDX_MODE, 8'h00, "mode reset");
    rd(`IDX_REF_SEL, 8'h00, "reference reset");
    rd(`IDX_IRQ_CTL, 8'h00, "irq reset");
    rd(8'h10, 8'h00, "unmapped read");
    check(conv_power_o, 1'b0, "power reset");
  endtask
  task automatic test_reference;
    wr(`IDX_REF_SEL, 8'h80);
    tick(2);
    check({ext_ref_pin_en_o, int_ref_tap_o}, 5'h10, "external ref");
    for (int l = 0; l < 4; l++)
    begin
      wr(`IDX_REF_SEL, 8'(l));
      tick(2);
      check({ext_ref_pin_en_o, int_ref_tap_o}, 5'(4'h1 << l), "internal level");
      rd(`IDX_REF_SEL, 8'(l), "reference readback");
    end
  endtask
  task automatic test_pins;
    wr(`IDX_PIN_CFG, 8'h15);
    tick(2);
    check(pin_analog_only_o, 5'h15, "analog only pins");
    rd(`IDX_PIN_CFG, 8'h00, "write-only readback");
    wr(`IDX_PIN_CFG, 8'h0a);
    tick(2);
    check(pin_analog_only_o, 5'h0a, "analog only pins");
  endtask
  task automatic test_channels;
    for (int c = 0; c < 7; c++)
    begin
      wr(`IDX_MODE, 8'h80 | 8'(c));
      tick(2);
      check(channel_sel_o, 6'h00, "route before enable");
      wr(`IDX_MODE, 8'h90 | 8'(c));
      tick(2);
      check(channel_sel_o, c < 6 ? 6'(6'h01 << c) : 6'h00, "channel route");
    end
    wr(`IDX_REF_SEL, 8'h80);
    wr(`IDX_MODE, 8'h90);
    tick(2);
    check(channel_sel_o, 6'h00, "pin zero taken by reference");
    wr(`IDX_REF_SEL, 8'h03);
  endtask
  task automatic conv(input logic [1:0] div, input logic res, input logic [1:0] lv, input logic [11:0] exp);
    int n;
    int len;
    logic [7:0] cr;
    cr = {1'b0, div[1], res, div[0], 4'h0};
    level <= lv;
    len = (res ? 64 : 48) * (div == 2'h0 ? 16 : div == 2'h1 ? 8 : div == 2'h2 ? 1 : 2);
    wr(`IDX_CLK_RES, cr);
    wr(`IDX_IRQ_CTL, 8'h02);
    wr(`IDX_MODE, 8'hd2);
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
      if (n == 3) check(converting_o, 1'b1, "converting while busy");
    end while (conv_irq_o !== 1'b1 && n < 2000);
    check(converting_o, 1'b0, "converting after end");
    if (offset < 0)
    begin
      offset = n - len;
      check(offset == 3 || offset == 4, 1'b1, "start to flag latency");
    end
    check(n - len, offset, "conversion length");
    rd(`IDX_MODE, 8'hb2, "end flag and start clear");
    rd(`IDX_IRQ_CTL, 8'h03, "irq flag");
    rd(`IDX_RES_HI, exp[11:4], "result high");
    rd(`IDX_CLK_RES, cr | 8'(exp[3:0]), "result low");
  endtask
  task automatic test_restart;
    wr(`IDX_IRQ_CTL, 8'h02);
    wr(`IDX_MODE, 8'hd2);
    rd(`IDX_MODE, 8'hd2, "start clears end flag");
    wr(`IDX_MODE, 8'h92);
    tick(200);
    check(conv_irq_o, 1'b0, "aborted run raises nothing");
    rd(`IDX_MODE, 8'h92, "abort leaves no end flag");
    check(converting_o, 1'b0, "abort stops conversion");
    wr(`IDX_MODE, 8'h50);
    tick(4);
    check(converting_o, 1'b0, "start refused without power");
    rd(`IDX_MODE, 8'h10, "start bit refused without power");
  endtask

  initial
  begin
    #400_000;
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    tick(16);
    rst_i <= 1'b0;
    test_reset();
    test_reference();
    test_pins();
    // Bring-up in the order software must follow
    wr(`IDX_MODE, 8'h00);
    wr(`IDX_CLK_RES, 8'h20);
    wr(`IDX_REF_SEL, 8'h03);
    wr(`IDX_PIN_CFG, 8'h1f);
    wr(`IDX_MODE, 8'h80);
    tick(5000);
    check(conv_power_o, 1'b1, "power on");
    test_channels();
    conv(2'h0, 1'b1, 2'h0, 12'h5a2);
    conv(2'h1, 1'b1, 2'h0, 12'h5a2);
    conv(2'h2, 1'b1, 2'h1, `RESULT_FULL);
    conv(2'h3, 1'b1, 2'h2, `RESULT_ZERO);
    conv(2'h2, 1'b0, 2'h0, 12'h5a2);
    conv(2'h3, 1'b0, 2'h3, `RESULT_FULL);
    test_restart();
    report_and_stop();
  end
endmodule
